// [sbsp_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_cfg.svh"

// Notes on behaviour
// RULE_01: Any lane write low means write cycle.
// RULE_02: Each lane gates one byte plus parity.
// RULE_03: Inputs sampled on rising edge; enable asynchronous.
// RULE_04: Inactive advance holds burst address (wait state).
// RULE_05: Host keeps output enable high around writes.
// RULE_06: Data outputs stay undriven at power-up.
// RULE_07: Parity disable high turns parity lines off.
// RULE_08: Processor strobe reads; write follows next edge.
// RULE_09: Write needs lane low and processor strobe high.
// RULE_10: Output enable ignored while lane write low.
// RULE_11: Host holds address and controls stable.
// RULE_12: Host presents valid chip enables with strobes.
// RULE_13: Deselect cycle powers down; select makes active.
// RULE_14: Host keeps advance high writing loaded address.
// RULE_15: Secondary selects sampled like the primary select.
// RULE_16: Two devices pair by secondary selects.
// RULE_17: Burst counter uses interleaved order, wraps four.
// RULE_18: Processor strobe ignored while primary select inactive.
// RULE_19: Controller strobe loads only when fully selected.
// RULE_20: Written word shows in output register next.
// RULE_21: Burst changes only two low address bits.
module sbsp_device #(
  parameter int DEPTH = `SBSP_DEPTH
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  sbsp_if.device              bus,
  output logic                selected,
  output sbsp_pkg::sbsp_cyc_t cycle_kind,
  output sbsp_pkg::sbsp_addr_t burst_addr
);
  import sbsp_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  sbsp_dev_st_t             q;
  sbsp_dev_st_t             d;
  sbsp_word_t               mem [DEPTH];
  logic [`SBSP_LANES-1:0]   lane_n;
  logic                     ce_ok;
  logic                     processor_addr_strobe_n_take;
  logic                     controller_addr_strobe_n_take;
  logic                     wr_any;
  logic                     load;
  logic                     desel;
  logic                     cont;
  sbsp_addr_t               eff;
  sbsp_word_t               wmask;
  sbsp_word_t               wword;
  sbsp_word_t               merged;

  // --------------------------------------------------------------------
  // Cycle qualification
  // --------------------------------------------------------------------
  assign lane_n = {bus.lane4_write_n, bus.lane3_write_n,
                   bus.lane2_write_n, bus.lane1_write_n};

  assign wr_any = ~&lane_n;  // [RULE_01]

  // All three selects are looked at only together with a strobe.
  assign ce_ok = ~bus.chip_select_n & ~bus.secondary_select_n
               & bus.secondary_select;  // [RULE_15]

  assign processor_addr_strobe_n_take = ~bus.processor_addr_strobe_n
                   & ~bus.chip_select_n;  // [RULE_18]

  // A processor strobe that is taken wins over the controller strobe.
  assign controller_addr_strobe_n_take = ~bus.controller_addr_strobe_n & ~processor_addr_strobe_n_take;

  assign load  = (processor_addr_strobe_n_take | controller_addr_strobe_n_take) & ce_ok;  // [RULE_19]
  assign desel = (processor_addr_strobe_n_take | controller_addr_strobe_n_take) & ~ce_ok;  // [RULE_13]
  assign cont  = ~processor_addr_strobe_n_take & ~controller_addr_strobe_n_take & q.selected;

  // --------------------------------------------------------------------
  // Byte lanes
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SBSP_LANES; gi++)
    begin : g_lane
      assign wmask[gi*`SBSP_LANE_W +: `SBSP_LANE_W] =
        {`SBSP_LANE_W{~lane_n[gi]}};  // [RULE_02]
      assign wword[gi*`SBSP_LANE_W +: `SBSP_LANE_W] =
        bus.data_lines[gi*`SBSP_LANE_W +: `SBSP_LANE_W];
      // A disabled parity lane keeps its stored bit untouched.
      assign wmask[`SBSP_PAR_LSB + gi] =
        ~lane_n[gi] & ~bus.parity_lane_disable;  // [RULE_07]
      assign wword[`SBSP_PAR_LSB + gi] = bus.parity_lines[gi];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (load)
    begin
      d.addr_hi  = bus.addr[`SBSP_ADDR_W-1:`SBSP_LO_W];  // [RULE_21]
      d.start_lo = bus.addr[`SBSP_LO_W-1:0];
      d.cnt      = '0;
      d.selected = 1'b1;
      // A taken processor strobe always reads, whatever the lanes say.
      if (processor_addr_strobe_n_take || !wr_any)
      begin
        d.cyc = SBSP_CYC_READ;  // [RULE_08] [RULE_09]
      end
      else
      begin
        d.cyc = SBSP_CYC_WRITE;  // [RULE_09]
      end
    end
    else if (desel)
    begin
      d.selected = 1'b0;  // [RULE_13]
      d.cyc      = SBSP_CYC_IDLE;
    end
    else if (cont)
    begin
      if (!bus.burst_advance_n)
      begin
        // Two-bit count wraps by itself after the fourth access.
        d.cnt = q.cnt + `SBSP_CNT_STEP;  // [RULE_17]
      end
      // With advance high the count is left alone: a wait state.
      // [RULE_04]
      if (wr_any)
      begin
        d.cyc = SBSP_CYC_WRITE;  // [RULE_08]
      end
      else
      begin
        d.cyc = SBSP_CYC_READ;
      end
    end
    else
    begin
      d.cyc = SBSP_CYC_IDLE;
    end

    // Interleaved order is the start bits exclusive-ored with the count.
    eff    = {d.addr_hi, d.start_lo ^ d.cnt};  // [RULE_17] [RULE_21]
    merged = (mem[eff] & ~wmask) | (wword & wmask);
    if (d.cyc == SBSP_CYC_WRITE)
    begin
      // Written data is passed straight into the output register.
      d.out = merged;  // [RULE_20]
    end
    else if (d.cyc == SBSP_CYC_READ)
    begin
      d.out = mem[eff];
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;  // [RULE_06]
    end
    else
    begin
      q <= d;  // [RULE_03]
    end
  end

  // The array has no reset; its contents are unknown until written.
  always_ff @(posedge clk)
  begin
    if (d.cyc == SBSP_CYC_WRITE)
    begin
      mem[eff] <= merged;  // [RULE_02]
    end
  end

  // --------------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------------
  // The enable path is pure gating so that it acts without the clock.
  assign bus.dev_dq_oe = q.selected & ~bus.output_enable_n
                       & ~wr_any;  // [RULE_03] [RULE_10] [RULE_13]
  assign bus.dev_parity_oe = bus.dev_dq_oe
                           & ~bus.parity_lane_disable;  // [RULE_07]
  assign bus.dev_dq_out     = q.out[`SBSP_DATA_W-1:0];
  assign bus.dev_parity_out = q.out[`SBSP_WORD_W-1:`SBSP_PAR_LSB];

  assign selected   = q.selected;
  assign cycle_kind = q.cyc;
  assign burst_addr = {q.addr_hi, q.start_lo ^ q.cnt};

endmodule

`default_nettype wire

// [sbsp_cfg.svh]
`ifndef SBSP_CFG_SVH
`define SBSP_CFG_SVH

// ----------------------------------------------------------------------
// Array shape and pin widths
// ----------------------------------------------------------------------
`define SBSP_ADDR_W     15
`define SBSP_LO_W       2
`define SBSP_HI_W       13
`define SBSP_DEPTH      32768
`define SBSP_LANES      4
`define SBSP_LANE_W     8
`define SBSP_DATA_W     32
`define SBSP_WORD_W     36
`define SBSP_PAR_LSB    32

// ----------------------------------------------------------------------
// Burst and reset values
// ----------------------------------------------------------------------
`define SBSP_BURST_LAST 2'h3
`define SBSP_BEAT_ONE   2'h1
`define SBSP_CNT_STEP   2'h1
`define SBSP_LANES_OFF  4'hf

`endif

// [sbsp_pkg.sv]
`include "sbsp_cfg.svh"

package sbsp_pkg;

  // --------------------------------------------------------------------
  // Shared types
  // --------------------------------------------------------------------
  typedef logic [`SBSP_ADDR_W-1:0] sbsp_addr_t;
  typedef logic [`SBSP_WORD_W-1:0] sbsp_word_t;

  typedef enum logic [1:0] {
    SBSP_CYC_IDLE  = 2'h0,
    SBSP_CYC_READ  = 2'h1,
    SBSP_CYC_WRITE = 2'h3
  } sbsp_cyc_t;

  typedef enum logic [1:0] {
    SBSP_H_IDLE  = 2'h0,
    SBSP_H_LOAD  = 2'h1,
    SBSP_H_BEAT  = 2'h3,
    SBSP_H_WRITE = 2'h2
  } sbsp_hst_t;

  typedef struct packed {
    sbsp_cyc_t              cyc;
    logic                   selected;
    logic [`SBSP_HI_W-1:0]  addr_hi;
    logic [`SBSP_LO_W-1:0]  start_lo;
    logic [`SBSP_LO_W-1:0]  cnt;
    sbsp_word_t             out;
  } sbsp_dev_st_t;

  typedef struct packed {
    sbsp_hst_t              st;
    logic [`SBSP_LO_W-1:0]  beats;
    logic                   ce_n;
    logic                   processor_addr_strobe_n_n;
    logic                   controller_addr_strobe_n_n;
    logic                   adv_n;
    logic [`SBSP_LANES-1:0] bw_n;
    logic                   oe_n;
    sbsp_addr_t             addr;
    sbsp_word_t             wdata;
    logic                   drive;
    logic                   rsp_valid;
    sbsp_word_t             rsp_data;
  } sbsp_hst_st_t;

endpackage

// [sbsp_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_cfg.svh"

interface sbsp_if;
  logic [`SBSP_ADDR_W-1:0]  addr;
  logic                     chip_select_n;
  logic                     secondary_select_n;
  logic                     secondary_select;
  logic                     processor_addr_strobe_n;
  logic                     controller_addr_strobe_n;
  logic                     burst_advance_n;
  logic                     lane1_write_n;
  logic                     lane2_write_n;
  logic                     lane3_write_n;
  logic                     lane4_write_n;
  logic                     output_enable_n;
  logic                     parity_lane_disable;
  logic [`SBSP_DATA_W-1:0]  host_dq_out;
  logic [`SBSP_LANES-1:0]   host_parity_out;
  logic                     host_dq_oe;
  logic [`SBSP_DATA_W-1:0]  dev_dq_out;
  logic [`SBSP_LANES-1:0]   dev_parity_out;
  logic                     dev_dq_oe;
  logic                     dev_parity_oe;
  logic [`SBSP_DATA_W-1:0]  data_lines;
  logic [`SBSP_LANES-1:0]   parity_lines;

  // --------------------------------------------------------------------
  // Shared wire levels
  // --------------------------------------------------------------------
  // An undriven line reads as zero; contention is not modelled.
  assign data_lines   = dev_dq_oe ? dev_dq_out :
                        (host_dq_oe ? host_dq_out : '0);
  assign parity_lines = dev_parity_oe ? dev_parity_out :
                        (host_dq_oe ? host_parity_out : '0);

  modport device (
    input  addr, chip_select_n, secondary_select_n, secondary_select,
    input  processor_addr_strobe_n, controller_addr_strobe_n,
    input  burst_advance_n, lane1_write_n, lane2_write_n,
    input  lane3_write_n, lane4_write_n, output_enable_n,
    input  parity_lane_disable, data_lines, parity_lines,
    output dev_dq_out, dev_parity_out, dev_dq_oe, dev_parity_oe
  );

  modport host (
    output addr, chip_select_n, secondary_select_n, secondary_select,
    output processor_addr_strobe_n, controller_addr_strobe_n,
    output burst_advance_n, lane1_write_n, lane2_write_n,
    output lane3_write_n, lane4_write_n, output_enable_n,
    output parity_lane_disable, host_dq_out, host_parity_out,
    output host_dq_oe,
    input  data_lines, parity_lines
  );
endinterface

`default_nettype wire

// [sbsp_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_cfg.svh"

module sbsp_host #(
  parameter logic PARITY_OFF = 1'b0
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  sbsp_if.host                         bus,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire logic                    cmd_write,
  input  wire logic                    cmd_burst,
  input  wire sbsp_pkg::sbsp_addr_t    cmd_addr,
  input  wire logic [`SBSP_LANES-1:0]  cmd_lanes,
  input  wire sbsp_pkg::sbsp_word_t    cmd_wdata,
  output logic                         rsp_valid,
  output sbsp_pkg::sbsp_word_t         rsp_data
);
  import sbsp_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  localparam sbsp_hst_st_t RST = '{
    st: SBSP_H_IDLE, beats: '0, ce_n: 1'b1, processor_addr_strobe_n_n: 1'b1, controller_addr_strobe_n_n: 1'b1,
    adv_n: 1'b1, bw_n: `SBSP_LANES_OFF, oe_n: 1'b1, addr: '0,
    wdata: '0, drive: 1'b0, rsp_valid: 1'b0, rsp_data: '0};

  sbsp_hst_st_t q;
  sbsp_hst_st_t d;

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.rsp_valid = 1'b0;
    unique case (q.st)
      SBSP_H_IDLE:
      begin
        if (cmd_valid)
        begin
          d.addr = cmd_addr;  // [RULE_11]
          d.ce_n = 1'b0;  // [RULE_12] [RULE_16]
          if (cmd_write)
          begin
            // Writes go through the controller strobe with advance high.
            d.controller_addr_strobe_n_n = 1'b0;
            d.adv_n  = 1'b1;  // [RULE_14]
            d.bw_n   = ~cmd_lanes;  // [RULE_08]
            d.wdata  = cmd_wdata;
            d.drive  = 1'b1;
            d.oe_n   = 1'b1;  // [RULE_05]
            d.st     = SBSP_H_WRITE;
          end
          else
          begin
            d.processor_addr_strobe_n_n = cmd_burst;
            d.controller_addr_strobe_n_n = ~cmd_burst;
            d.oe_n   = 1'b0;
            d.beats  = cmd_burst ? `SBSP_BURST_LAST : '0;
            d.st     = SBSP_H_LOAD;
          end
        end
      end
      SBSP_H_WRITE:
      begin
        d.controller_addr_strobe_n_n = 1'b1;
        d.ce_n   = 1'b1;
        d.bw_n   = `SBSP_LANES_OFF;
        d.drive  = 1'b0;
        d.st     = SBSP_H_IDLE;
      end
      SBSP_H_LOAD:
      begin
        d.processor_addr_strobe_n_n = 1'b1;
        d.controller_addr_strobe_n_n = 1'b1;
        d.ce_n   = 1'b1;
        d.adv_n  = (q.beats == '0);
        d.st     = SBSP_H_BEAT;
      end
      SBSP_H_BEAT:
      begin
        d.rsp_valid = 1'b1;
        d.rsp_data  = {bus.parity_lines, bus.data_lines};
        if (q.beats == '0)
        begin
          // Output enable rises a full cycle before any following write.
          d.oe_n  = 1'b1;  // [RULE_05]
          d.adv_n = 1'b1;
          d.st    = SBSP_H_IDLE;
        end
        else
        begin
          d.beats = q.beats - `SBSP_BEAT_ONE;
          d.adv_n = (q.beats == `SBSP_BEAT_ONE);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= RST;
    end
    else
    begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------
  assign bus.addr                     = q.addr;
  assign bus.chip_select_n            = q.ce_n;
  assign bus.secondary_select_n       = q.ce_n;
  assign bus.secondary_select         = ~q.ce_n;
  assign bus.processor_addr_strobe_n  = q.processor_addr_strobe_n_n;
  assign bus.controller_addr_strobe_n = q.controller_addr_strobe_n_n;
  assign bus.burst_advance_n          = q.adv_n;
  assign bus.lane1_write_n            = q.bw_n[0];
  assign bus.lane2_write_n            = q.bw_n[1];
  assign bus.lane3_write_n            = q.bw_n[2];
  assign bus.lane4_write_n            = q.bw_n[3];
  assign bus.output_enable_n          = q.oe_n;
  assign bus.parity_lane_disable      = PARITY_OFF;
  assign bus.host_dq_out              = q.wdata[`SBSP_DATA_W-1:0];
  assign bus.host_parity_out =
    q.wdata[`SBSP_WORD_W-1:`SBSP_PAR_LSB];
  assign bus.host_dq_oe               = q.drive;

  assign cmd_ready = (q.st == SBSP_H_IDLE);
  assign rsp_valid = q.rsp_valid;
  assign rsp_data  = q.rsp_data;

endmodule

`default_nettype wire

// [sbsp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_cfg.svh"

module sbsp_properties (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     chip_select_n,
  input wire logic                     secondary_select_n,
  input wire logic                     secondary_select,
  input wire logic                     processor_addr_strobe_n,
  input wire logic                     controller_addr_strobe_n,
  input wire logic                     burst_advance_n,
  input wire logic                     lane1_write_n,
  input wire logic                     lane2_write_n,
  input wire logic                     lane3_write_n,
  input wire logic                     lane4_write_n,
  input wire logic                     output_enable_n,
  input wire logic                     parity_lane_disable,
  input wire logic [`SBSP_DATA_W-1:0]  data_lines,
  input wire logic [`SBSP_LANES-1:0]   parity_lines,
  input wire logic [`SBSP_DATA_W-1:0]  dev_dq_out,
  input wire logic [`SBSP_LANES-1:0]   dev_parity_out,
  input wire logic                     dev_dq_oe,
  input wire logic                     dev_parity_oe
);
  // --------------------------------------------------------------------
  // Decoded cycle kinds
  // --------------------------------------------------------------------
  logic       all_sel;
  logic       any_lane;
  logic       wr_load;
  logic [8:0] lane1_in;
  logic [8:0] lane4_in;

  assign all_sel  = !chip_select_n && !secondary_select_n && secondary_select;
  assign any_lane = !(lane1_write_n && lane2_write_n &&
                      lane3_write_n && lane4_write_n);
  assign wr_load  = all_sel && processor_addr_strobe_n &&
                    !controller_addr_strobe_n && any_lane;
  assign lane1_in = {parity_lines[0], data_lines[7:0]};
  assign lane4_in = {parity_lines[3], data_lines[31:24]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Reset stands in for power-up, so this one must run while it is low.
  property p_quiet_reset;
    disable iff (1'b0) !rst_n |-> !dev_dq_oe && !dev_parity_oe;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset)
    else $error("outputs driven during reset");

  property p_lane_gate;
    any_lane |-> !dev_dq_oe && !dev_parity_oe;
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("outputs driven in a write cycle");

  property p_oe_gate;
    output_enable_n |-> !dev_dq_oe;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("outputs driven with enable off");

  property p_par_follow;
    !parity_lane_disable |-> dev_parity_oe == dev_dq_oe;
  endproperty
  a_par_follow: assert property (p_par_follow)
    else $error("parity drive differs from data drive");

  property p_read_drive;
    all_sel && !processor_addr_strobe_n
      |=> output_enable_n || any_lane || dev_dq_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read load did not drive the lines");

  property p_write_all;
    wr_load && !lane1_write_n && !lane2_write_n &&
      !lane3_write_n && !lane4_write_n |=> dev_dq_out == $past(data_lines);
  endproperty
  a_write_all: assert property (p_write_all)
    else $error("written word not in output register");

  property p_lane1;
    wr_load && !lane1_write_n
      |=> {dev_parity_out[0], dev_dq_out[7:0]} == $past(lane1_in);
  endproperty
  a_lane1: assert property (p_lane1)
    else $error("first byte lane not written");

  property p_lane4;
    wr_load && !lane4_write_n
      |=> {dev_parity_out[3], dev_dq_out[31:24]} == $past(lane4_in);
  endproperty
  a_lane4: assert property (p_lane4)
    else $error("last byte lane not written");

  property p_hold;
    processor_addr_strobe_n && controller_addr_strobe_n &&
      burst_advance_n && !any_lane |=> $stable(dev_dq_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved during a suspended burst");

  property p_oe_write;
    any_lane |-> output_enable_n;
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("enable low while writing");

  property p_adv_write;
    wr_load |-> burst_advance_n;
  endproperty
  a_adv_write: assert property (p_adv_write)
    else $error("advance low on a write load");
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_cfg.svh"

module testbench;
  import sbsp_pkg::*;

  logic                   clk;
  logic                   rst_n;
  logic                   cmd_valid;
  logic                   cmd_ready;
  logic                   cmd_write;
  logic                   cmd_burst;
  sbsp_addr_t             cmd_addr;
  logic [`SBSP_LANES-1:0] cmd_lanes;
  sbsp_word_t             cmd_wdata;
  logic                   rsp_valid;
  sbsp_word_t             rsp_data;
  logic                   selected;
  sbsp_cyc_t              cycle_kind;
  sbsp_addr_t             burst_addr;
  sbsp_addr_t             base;
  sbsp_word_t             mem [sbsp_addr_t];
  int                     fails;
  int                     n_compared;

  sbsp_if bus ();

  sbsp_device sbsp_device_inst (.clk, .rst_n, .bus, .selected, .cycle_kind,
    .burst_addr);

  sbsp_host sbsp_host_inst (.clk, .rst_n, .bus, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_burst, .cmd_addr, .cmd_lanes, .cmd_wdata, .rsp_valid,
    .rsp_data);

  sbsp_properties sbsp_properties_inst (.clk, .rst_n,
    .chip_select_n(bus.chip_select_n),
    .secondary_select_n(bus.secondary_select_n),
    .secondary_select(bus.secondary_select),
    .processor_addr_strobe_n(bus.processor_addr_strobe_n),
    .controller_addr_strobe_n(bus.controller_addr_strobe_n),
    .burst_advance_n(bus.burst_advance_n),
    .lane1_write_n(bus.lane1_write_n),
    .lane2_write_n(bus.lane2_write_n),
    .lane3_write_n(bus.lane3_write_n),
    .lane4_write_n(bus.lane4_write_n),
    .output_enable_n(bus.output_enable_n),
    .parity_lane_disable(bus.parity_lane_disable),
    .data_lines(bus.data_lines),
    .parity_lines(bus.parity_lines),
    .dev_dq_out(bus.dev_dq_out),
    .dev_parity_out(bus.dev_parity_out),
    .dev_dq_oe(bus.dev_dq_oe),
    .dev_parity_oe(bus.dev_parity_oe));

  // --------------------------------------------------------------------
  // Compare, wait and access tasks
  // --------------------------------------------------------------------
  task automatic finish_test;
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input sbsp_word_t got, input sbsp_word_t exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // Looks at negative edges so a one-cycle pulse is never missed by a race.
  task automatic wait_for(input logic rsp);
    for (int n = 0; n < 20; n++)
    begin
      @(negedge clk);
      if ((rsp ? rsp_valid : cmd_ready) === 1'b1)
        return;
    end
    fails++;
    $display("wrong value at %0t: handshake never came", $time);
    finish_test();
  endtask

  task automatic issue(input logic w, input logic b, input sbsp_addr_t a,
                       input logic [3:0] l, input sbsp_word_t d);
    sbsp_cyc_t kind;
    kind = w ? SBSP_CYC_WRITE : SBSP_CYC_READ;
    wait_for(1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_burst <= b;
    cmd_addr <= a;
    cmd_lanes <= l;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(selected, 1'b1);
    chk_bit(cmd_ready, w);
    chk_bit(cycle_kind === kind, 1'b1);
    chk_bit(burst_addr === a, 1'b1);
  endtask

  task automatic wr(input sbsp_addr_t a, input logic [3:0] l,
                    input sbsp_word_t d);
    issue(1'b1, 1'b0, a, l, d);
    for (int i = 0; i < 4; i++)
      if (l[i])
      begin
        mem[a][8*i +: 8] = d[8*i +: 8];
        mem[a][32 + i] = d[32 + i];
      end
  endtask

  task automatic rd(input sbsp_addr_t a, input logic b);
    issue(1'b0, b, a, 4'h0, '0);
    for (int k = 0; k < (b ? 4 : 1); k++)
    begin
      wait_for(1'b1);
      chk_word(rsp_data, mem[{a[14:2], a[1:0] ^ k[1:0]}]);
    end
  endtask

  // --------------------------------------------------------------------
  // Clock and test sequence
  // --------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_burst = 1'b0;
    cmd_addr = '0;
    cmd_lanes = '0;
    cmd_wdata = '0;
    // A real falling edge lets the asynchronous reset take hold whatever
    // order the processes happen to start in at time zero.
    #1;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    chk_bit(bus.dev_dq_oe, 1'b0);
    chk_bit(bus.dev_parity_oe, 1'b0);
    rst_n <= 1'b1;
    $display("test power_up finished");
    // The top block makes bursts wrap at the last address of the array.
    for (int j = 0; j < 2; j++)
    begin
      base = j ? 15'h7ffc : 15'h4a5c;
      for (int i = 0; i < 4; i++)
      begin
        wr(base+15'(i), 4'hf, {4'(i+5), 17'h1_2345, base+15'(i)});
        rd(base + 15'(i), 1'b0);
      end
      for (int k = 1; k < 16; k += 5)
      begin
        wr(base + 15'h1, 4'(k), {~4'(k), {4{4'(k), 4'h3}}});
        rd(base + 15'h1, 1'b0);
      end
      for (int s = 0; s < 4; s++)
        rd(base + 15'(s), 1'b1);
      $display("test block %0d finished", j);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(bus.dev_dq_oe, 1'b0);
    chk_bit(selected, 1'b0);
    chk_bit(cycle_kind === SBSP_CYC_IDLE, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(15'h7ffd, 1'b0);
    $display("test second_reset finished");
    finish_test();
  end
endmodule

`default_nettype wire
